// >>> rtl/bwc_params.svh
`ifndef BWC_PARAMS_SVH
`define BWC_PARAMS_SVH

// Register byte offsets
`define BWC_OFF_PF_BOTTOM_HIGH  8'h28
`define BWC_OFF_PF_TOP_HIGH     8'h2c
`define BWC_OFF_IO_HIGH         8'h30
`define BWC_OFF_CAP_POINTER     8'h34
`define BWC_OFF_INT_CTRL        8'h3c

// Field positions in the shared dwords
`define BWC_IO_BOTTOM_MSB       15
`define BWC_IO_BOTTOM_LSB       0
`define BWC_IO_TOP_MSB          31
`define BWC_IO_TOP_LSB          16
`define BWC_INT_LINE_MSB        7
`define BWC_INT_LINE_LSB        0
`define BWC_INT_PIN_MSB         15
`define BWC_INT_PIN_LSB         8
`define BWC_CTL_PARITY_BIT      16
`define BWC_CTL_SERR_BIT        17
`define BWC_CTL_ISA_BIT         18

// Values and reset values
`define BWC_RST_PF_HIGH         32'h0000_0000
`define BWC_RST_IO_HIGH         16'h0000
`define BWC_RST_INT_LINE        8'h00
`define BWC_RST_CTL_BIT         1'b0
`define BWC_CAP_POINTER_VAL     8'hdc
`define BWC_INT_PIN_VAL         8'h00

`endif

// >>> rtl/bwc_pkg.sv
package bwc_pkg;

   typedef logic [7:0]  bwc_addr_t;
   typedef logic [31:0] bwc_word_t;
   typedef logic [63:0] bwc_mem_addr_t;

endpackage

// >>> rtl/bwc_win_if.sv
`timescale 1ns/1ps
`default_nettype none

interface bwc_win_if;
   bwc_pkg::bwc_mem_addr_t pf_base;
   bwc_pkg::bwc_mem_addr_t pf_limit;
   bwc_pkg::bwc_mem_addr_t mem_addr;
   bwc_pkg::bwc_word_t     io_base;
   bwc_pkg::bwc_word_t     io_limit;
   bwc_pkg::bwc_word_t     io_addr;
   logic                   pf_hit;
   logic                   io_in_win;
   logic                   isa_region;

   modport regs (
      output pf_base, pf_limit, mem_addr, io_base, io_limit, io_addr,
      input  pf_hit, io_in_win, isa_region
   );

   modport matcher (
      input  pf_base, pf_limit, mem_addr, io_base, io_limit, io_addr,
      output pf_hit, io_in_win, isa_region
   );
endinterface

`default_nettype wire

// >>> rtl/bwc_window_match.sv
`timescale 1ns/1ps
`default_nettype none

module bwc_window_match (
   bwc_win_if.matcher win
);

   function automatic logic bwc_in_range(
      input logic [63:0] base,
      input logic [63:0] limit,
      input logic [63:0] addr
   );
      bwc_in_range = (base <= addr) && (addr <= limit);
   endfunction

   // Window compare, inclusive at both ends
   always_comb begin
      win.pf_hit    = bwc_in_range(win.pf_base, win.pf_limit, win.mem_addr);
      win.io_in_win = bwc_in_range({32'h0000_0000, win.io_base},
                                   {32'h0000_0000, win.io_limit},
                                   {32'h0000_0000, win.io_addr});
   end

   // First 64KB, last 768 bytes of each 1KB block
   always_comb begin
      win.isa_region = (win.io_addr[31:16] == 16'h0000) &&
                       (win.io_addr[9:8] != 2'b00);
   end

endmodule // bwc_window_match

`default_nettype wire

// >>> rtl/bwc_regs.sv
// Behaviour
// - Prefetch bottom upper dword, RW, resets zero
// - Prefetch top upper dword, RW, resets zero
// - I/O bottom upper half, RW, resets zero
// - I/O top upper half, RW, resets zero
// - Capability pointer reads fixed DCh
// - Interrupt line byte is plain storage
// - Interrupt pin byte read-only, no pin
// - Parity bit gates secondary parity reporting
// - Error-forward bit gates secondary system error
// - ISA bit acts only in window, below 64KB
// - ISA set blocks last 768 bytes downstream
`timescale 1ns/1ps
`default_nettype none
`include "bwc_params.svh"

module bwc_regs (
   input  wire logic                   core_clk_in,
   input  wire logic                   reset_n_in,
   input  wire bwc_pkg::bwc_addr_t     reg_addr_in,
   input  wire bwc_pkg::bwc_word_t     reg_wdata_in,
   input  wire logic                   reg_wr_in,
   input  wire logic                   reg_rd_in,
   output var  bwc_pkg::bwc_word_t     reg_rdata_out,
   input  wire logic [11:0]            pf_base_low_in,
   input  wire logic [11:0]            pf_limit_low_in,
   input  wire logic [3:0]             io_base_low_in,
   input  wire logic [3:0]             io_limit_low_in,
   input  wire bwc_pkg::bwc_mem_addr_t mem_addr_in,
   input  wire bwc_pkg::bwc_word_t     io_addr_in,
   output var  logic                   pf_hit_out,
   output var  logic                   io_fwd_down_out,
   output var  logic                   io_fwd_up_out,
   input  wire logic                   sec_parity_err_in,
   input  wire logic                   secondary_system_error_n_in,
   output var  logic                   parity_err_report_out,
   output var  logic                   primary_serr_req_out,
   output var  logic                   parity_resp_en_out,
   output var  logic                   isa_enable_out
);

   ////////////////////////////////////////////////////////////////
   // Register storage

   bwc_pkg::bwc_word_t pf_bottom_high;
   bwc_pkg::bwc_word_t pf_top_high;
   logic [15:0]        io_bottom_high;
   logic [15:0]        io_top_high;
   logic [7:0]         int_line;
   logic               parity_resp_en;
   logic               serr_fwd_en;
   logic               isa_en;
   logic               serr_meta_n;
   logic               serr_sync_n;
   bwc_pkg::bwc_word_t next_rdata;

   logic wr_pf_bottom;
   logic wr_pf_top;
   logic wr_io;
   logic wr_int_ctrl;

   assign wr_pf_bottom = reg_wr_in && (reg_addr_in == `BWC_OFF_PF_BOTTOM_HIGH);
   assign wr_pf_top    = reg_wr_in && (reg_addr_in == `BWC_OFF_PF_TOP_HIGH);
   assign wr_io        = reg_wr_in && (reg_addr_in == `BWC_OFF_IO_HIGH);
   assign wr_int_ctrl  = reg_wr_in && (reg_addr_in == `BWC_OFF_INT_CTRL);

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         pf_bottom_high <= `BWC_RST_PF_HIGH;
      end else if (wr_pf_bottom) begin
         pf_bottom_high <= reg_wdata_in;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         pf_top_high <= `BWC_RST_PF_HIGH;
      end else if (wr_pf_top) begin
         pf_top_high <= reg_wdata_in;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         io_bottom_high <= `BWC_RST_IO_HIGH;
         io_top_high    <= `BWC_RST_IO_HIGH;
      end else if (wr_io) begin
         io_bottom_high <= reg_wdata_in[`BWC_IO_BOTTOM_MSB:`BWC_IO_BOTTOM_LSB];
         io_top_high    <= reg_wdata_in[`BWC_IO_TOP_MSB:`BWC_IO_TOP_LSB];
      end
   end

   // Interrupt line plus low bridge control bits; pin byte ignores writes
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         int_line       <= `BWC_RST_INT_LINE;
         parity_resp_en <= `BWC_RST_CTL_BIT;
         serr_fwd_en    <= `BWC_RST_CTL_BIT;
         isa_en         <= `BWC_RST_CTL_BIT;
      end else if (wr_int_ctrl) begin
         int_line       <= reg_wdata_in[`BWC_INT_LINE_MSB:`BWC_INT_LINE_LSB];
         parity_resp_en <= reg_wdata_in[`BWC_CTL_PARITY_BIT];
         serr_fwd_en    <= reg_wdata_in[`BWC_CTL_SERR_BIT];
         isa_en         <= reg_wdata_in[`BWC_CTL_ISA_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////
   // Read path, data one cycle after the strobe, zero otherwise

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (reg_rd_in) begin
         case (reg_addr_in)
            `BWC_OFF_PF_BOTTOM_HIGH: begin
               next_rdata = pf_bottom_high;
            end
            `BWC_OFF_PF_TOP_HIGH: begin
               next_rdata = pf_top_high;
            end
            `BWC_OFF_IO_HIGH: begin
               next_rdata = {io_top_high, io_bottom_high};
            end
            `BWC_OFF_CAP_POINTER: begin
               next_rdata = {24'h00_0000, `BWC_CAP_POINTER_VAL};
            end
            `BWC_OFF_INT_CTRL: begin
               next_rdata = {13'h0000, isa_en, serr_fwd_en, parity_resp_en,
                             `BWC_INT_PIN_VAL, int_line};
            end
            default: begin
               next_rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         reg_rdata_out <= 32'h0000_0000;
      end else begin
         reg_rdata_out <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Window decode

   bwc_win_if win ();

   always_comb begin
      win.pf_base  = {pf_bottom_high, pf_base_low_in, 20'h0_0000};
      win.pf_limit = {pf_top_high, pf_limit_low_in, 20'hf_ffff};
      win.io_base  = {io_bottom_high, io_base_low_in, 12'h000};
      win.io_limit = {io_top_high, io_limit_low_in, 12'hfff};
      win.mem_addr = mem_addr_in;
      win.io_addr  = io_addr_in;
   end

   bwc_window_match u_match (
      .win (win.matcher)
   );

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         pf_hit_out <= 1'b0;
      end else begin
         pf_hit_out <= win.pf_hit;
      end
   end

   // ISA blocking only inside the window and the first 64KB
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         io_fwd_down_out <= 1'b0;
         io_fwd_up_out   <= 1'b0;
      end else begin
         io_fwd_down_out <= win.io_in_win &&
                            !(isa_en && win.isa_region);
         io_fwd_up_out   <= !win.io_in_win ||
                            (isa_en && win.isa_region);
      end
   end

   ////////////////////////////////////////////////////////////////
   // Error gating

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         serr_meta_n <= 1'b1;
         serr_sync_n <= 1'b1;
      end else begin
         serr_meta_n <= secondary_system_error_n_in;
         serr_sync_n <= serr_meta_n;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         primary_serr_req_out <= 1'b0;
      end else begin
         primary_serr_req_out <= serr_fwd_en && !serr_sync_n;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         parity_err_report_out <= 1'b0;
      end else begin
         parity_err_report_out <= parity_resp_en && sec_parity_err_in;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         parity_resp_en_out <= 1'b0;
         isa_enable_out     <= 1'b0;
      end else begin
         parity_resp_en_out <= parity_resp_en;
         isa_enable_out     <= isa_en;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Checks

   pf_bottom_wr_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      reg_wr_in && (reg_addr_in == `BWC_OFF_PF_BOTTOM_HIGH) ##1 reg_rd_in &&
      (reg_addr_in == `BWC_OFF_PF_BOTTOM_HIGH) && !reg_wr_in
      |=> reg_rdata_out == $past(reg_wdata_in, 2))
      else $error("prefetch bottom readback wrong");

   pf_top_wr_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      wr_pf_top |=> pf_top_high == $past(reg_wdata_in))
      else $error("prefetch top not stored");

   io_bottom_wr_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      wr_io |=> io_bottom_high == $past(reg_wdata_in[15:0]))
      else $error("io bottom not stored");

   io_top_rd_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      reg_rd_in && (reg_addr_in == `BWC_OFF_IO_HIGH)
      |=> reg_rdata_out[31:16] == $past(io_top_high))
      else $error("io top readback wrong");

   cap_ptr_rd_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      reg_rd_in && (reg_addr_in == `BWC_OFF_CAP_POINTER)
      |=> reg_rdata_out == 32'h0000_00dc)
      else $error("capability pointer not DCh");

   int_line_rd_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      wr_int_ctrl ##1 (reg_rd_in && (reg_addr_in == `BWC_OFF_INT_CTRL))
      |=> reg_rdata_out[7:0] == $past(reg_wdata_in[7:0], 2))
      else $error("interrupt line not kept");

   int_pin_ro_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      reg_rd_in && (reg_addr_in == `BWC_OFF_INT_CTRL)
      |=> reg_rdata_out[15:8] == 8'h00)
      else $error("interrupt pin not zero");

   parity_gate_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      sec_parity_err_in |=> parity_err_report_out == $past(parity_resp_en))
      else $error("parity reporting not gated");

   serr_fwd_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      (serr_fwd_en && !secondary_system_error_n_in)[*3]
      |=> primary_serr_req_out)
      else $error("system error not forwarded");

   serr_block_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      !serr_fwd_en |=> !primary_serr_req_out)
      else $error("system error leaked");

   isa_scope_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      (io_addr_in[31:16] != 16'h0000) |=> io_fwd_down_out == $past(win.io_in_win))
      else $error("ISA block outside 64KB");

   isa_block_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      isa_en && win.io_in_win && (io_addr_in[31:16] == 16'h0000) &&
      (io_addr_in[9:8] != 2'b00) |=> !io_fwd_down_out && io_fwd_up_out)
      else $error("ISA alias not blocked");

   pf_hit_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      1'b1 |=> pf_hit_out == (($past(win.pf_base) <= $past(mem_addr_in)) &&
                              ($past(mem_addr_in) <= $past(win.pf_limit))))
      else $error("prefetch window compare wrong");

   reset_clear_a: assert property (@(posedge core_clk_in)
      !reset_n_in |=> (reg_rdata_out == 32'h0000_0000) && (pf_bottom_high == 32'h0000_0000) &&
      (pf_top_high == 32'h0000_0000) && !primary_serr_req_out && !parity_err_report_out)
      else $error("state not cleared by reset");

   pf_bottom_keep_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      wr_pf_bottom
      |=> pf_bottom_high == $past(reg_wdata_in))
      else $error("prefetch bottom not stored");

   pf_top_rd_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      reg_rd_in && (reg_addr_in == `BWC_OFF_PF_TOP_HIGH)
      |=> reg_rdata_out == $past(pf_top_high))
      else $error("prefetch top readback wrong");

   io_bottom_rd_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      reg_rd_in && (reg_addr_in == `BWC_OFF_IO_HIGH)
      |=> reg_rdata_out[15:0] == $past(io_bottom_high))
      else $error("io bottom readback wrong");

   io_top_wr_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      wr_io
      |=> io_top_high == $past(reg_wdata_in[31:16]))
      else $error("io top not stored");

   ctrl_rd_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      reg_rd_in && (reg_addr_in == `BWC_OFF_INT_CTRL)
      |=> (reg_rdata_out[31:19] == 13'h0000) &&
      (reg_rdata_out[18:16] == $past({isa_en, serr_fwd_en, parity_resp_en})))
      else $error("control bits readback wrong");

   parity_block_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      !parity_resp_en
      |=> !parity_err_report_out)
      else $error("parity reported while ignored");

   parity_mirror_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      1'b1
      |=> parity_resp_en_out == $past(parity_resp_en))
      else $error("parity enable copy wrong");

   serr_release_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      serr_sync_n
      |=> !primary_serr_req_out)
      else $error("system error held after release");

   isa_mirror_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      1'b1
      |=> isa_enable_out == $past(isa_en))
      else $error("ISA enable copy wrong");

   isa_clear_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      !isa_en
      |=> io_fwd_down_out == $past(win.io_in_win))
      else $error("window not fully forwarded");

   io_outside_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
      !win.io_in_win
      |=> io_fwd_up_out && !io_fwd_down_out)
      else $error("outside io address forwarded down");

endmodule // bwc_regs

`default_nettype wire

// >>> testbench/bwc_far_side.sv
`timescale 1ns/1ps
`default_nettype none

module bwc_far_side (
   input  wire logic       core_clk_in,
   input  wire logic       serr_cmd_in,
   input  wire logic [3:0] serr_len_in,
   output var  logic       secondary_system_error_n_out
);
   logic [3:0] low_left = 4'h0;

   // Pin is pulled up whenever no error event is active
   always_ff @(posedge core_clk_in) begin
      if (serr_cmd_in) begin
         low_left <= serr_len_in;
      end else if (low_left != 4'h0) begin
         low_left <= low_left - 4'h1;
      end
   end

   assign secondary_system_error_n_out = (low_left == 4'h0);
endmodule // bwc_far_side

`default_nettype wire

// >>> testbench/bridge_window_config_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none

module bridge_window_config_regs_bench;
   logic               clk = 1'b0;
   logic               rst_n = 1'b0;
   bwc_pkg::bwc_addr_t addr = 8'h00;
   bwc_pkg::bwc_word_t wdata = 32'h0;
   logic               wr = 1'b0;
   logic               rd = 1'b0;
   bwc_pkg::bwc_word_t rdata;
   logic [11:0]        pfb_lo = 12'h100;
   logic [11:0]        pft_lo = 12'h1ff;
   logic [3:0]         iob_lo = 4'h1;
   logic [3:0]         iot_lo = 4'h2;
   logic [63:0]        mem = 64'h0;
   logic [31:0]        io = 32'h0;
   logic               pf_hit, dn, up, par_err = 1'b0, par_rep, serr_req, par_en, isa_en;
   logic               serr_n, serr_cmd = 1'b0;
   logic [31:0]        pfb = 32'h0, pft = 32'h0;
   logic [15:0]        iob = 16'h0, iot = 16'h0;
   logic               isa = 1'b0;
   int                 bad_count = 0, comparisons = 0, cycles = 0;

   initial begin
      forever #4 clk = ~clk;
   end

   bwc_regs i_bwc_regs (
      .core_clk_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .pf_base_low_in(pfb_lo),
      .pf_limit_low_in(pft_lo), .io_base_low_in(iob_lo), .io_limit_low_in(iot_lo),
      .mem_addr_in(mem), .io_addr_in(io), .pf_hit_out(pf_hit), .io_fwd_down_out(dn),
      .io_fwd_up_out(up), .sec_parity_err_in(par_err),
      .secondary_system_error_n_in(serr_n), .parity_err_report_out(par_rep),
      .primary_serr_req_out(serr_req), .parity_resp_en_out(par_en),
      .isa_enable_out(isa_en)
   );

   bwc_far_side i_bwc_far_side (
      .core_clk_in(clk), .serr_cmd_in(serr_cmd), .serr_len_in(4'h4),
      .secondary_system_error_n_out(serr_n)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      if (bad_count == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         bad_count++;
         tally_and_finish;
      end
   end

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input bwc_pkg::bwc_addr_t a, input bwc_pkg::bwc_word_t d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      case (a)
         8'h28: pfb = d;
         8'h2c: pft = d;
         8'h30: {iot, iob} = d;
         8'h3c: isa = d[18];
         default: ;
      endcase
   endtask

   task automatic rd_check(input bwc_pkg::bwc_addr_t a, input bwc_pkg::bwc_word_t exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      check(rdata, exp);
   endtask

   // Expected pf hit, down, up from the programmed windows
   function automatic logic [2:0] expect_dec(input logic [63:0] m, input logic [31:0] a);
      logic [63:0] b, l;
      logic [31:0] ib, il;
      logic        inw, blk;
      b = {pfb, pfb_lo, 20'h0};
      l = {pft, pft_lo, 20'hfffff};
      ib = {iob, iob_lo, 12'h000};
      il = {iot, iot_lo, 12'hfff};
      inw = (ib <= a) && (a <= il);
      blk = isa && inw && (a[31:16] == 16'h0) && (a[9:8] != 2'b00);
      return {(b <= m) && (m <= l), inw && !blk, !inw || blk};
   endfunction

   task automatic dec_check(input logic [63:0] m, input logic [31:0] a);
      @(posedge clk);
      mem <= m;
      io <= a;
      @(posedge clk);
      @(negedge clk);
      check({pf_hit, dn, up}, expect_dec(m, a));
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_values;
      rd_check(8'h28, 32'h0);
      rd_check(8'h2c, 32'h0);
      rd_check(8'h30, 32'h0);
      rd_check(8'h34, 32'h0000_00dc);
      rd_check(8'h3c, 32'h0);
      rd_check(8'h40, 32'h0);
   endtask

   task automatic t_readback;
      wr_reg(8'h28, 32'ha5a5_5a5a);
      wr_reg(8'h2c, 32'h1234_5678);
      wr_reg(8'h30, 32'hdead_beef);
      wr_reg(8'h34, 32'hffff_ffff);
      wr_reg(8'h40, 32'hffff_ffff);
      wr_reg(8'h3c, 32'hffff_ffff);
      rd_check(8'h28, 32'ha5a5_5a5a);
      rd_check(8'h2c, 32'h1234_5678);
      rd_check(8'h30, 32'hdead_beef);
      rd_check(8'h34, 32'h0000_00dc);
      rd_check(8'h40, 32'h0);
      rd_check(8'h3c, 32'h0007_00ff);
      check({par_en, isa_en}, 2'b11);
      wr_reg(8'h3c, 32'h0000_00ff);
      rd_check(8'h3c, 32'h0000_00ff);
      check({par_en, isa_en}, 2'b00);
   endtask

   task automatic t_windows;
      logic [63:0] m_tab [8];
      logic [31:0] io_tab [8];
      m_tab = '{64'h1_0fff_ffff, 64'h1_1000_0000, 64'h1_1fff_ffff, 64'h1_2000_0000,
                64'h0_1000_0000, 64'h1_1800_0000, 64'h2_1000_0000, 64'h1_1000_0001};
      io_tab = '{32'h0fff, 32'h1000, 32'h10ff, 32'h1100, 32'h13ff, 32'h1400,
                 32'h2fff, 32'h3000};
      wr_reg(8'h28, 32'h1);
      wr_reg(8'h2c, 32'h1);
      wr_reg(8'h30, 32'h0);
      for (int pass = 0; pass < 2; pass++) begin
         wr_reg(8'h3c, pass ? 32'h0004_0000 : 32'h0);
         for (int i = 0; i < 8; i++) begin
            dec_check(m_tab[i], io_tab[i]);
         end
      end
      wr_reg(8'h30, 32'h0001_0001);
      dec_check(64'h0, 32'h1_1100);
      dec_check(64'h0, 32'h1_2fff);
      dec_check(64'h0, 32'h1_3000);
   endtask

   task automatic par_pulse(input logic exp);
      @(posedge clk);
      par_err <= 1'b1;
      @(posedge clk);
      par_err <= 1'b0;
      @(negedge clk);
      check(par_rep, exp);
      @(negedge clk);
      check(par_rep, 1'b0);
   endtask

   task automatic serr_event(input logic exp);
      @(posedge clk);
      serr_cmd <= 1'b1;
      @(posedge clk);
      serr_cmd <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      check(serr_req, 1'b0);
      @(negedge clk);
      check(serr_req, exp);
      repeat (8) @(posedge clk);
      @(negedge clk);
      check(serr_req, 1'b0);
   endtask

   task automatic t_errors;
      wr_reg(8'h3c, 32'h0);
      par_pulse(1'b0);
      serr_event(1'b0);
      wr_reg(8'h3c, 32'h0001_0000);
      par_pulse(1'b1);
      serr_event(1'b0);
      wr_reg(8'h3c, 32'h0002_0000);
      par_pulse(1'b0);
      serr_event(1'b1);
   endtask

   task automatic t_second_reset;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      pfb = 32'h0;
      isa = 1'b0;
      rd_check(8'h28, 32'h0);
      rd_check(8'h3c, 32'h0);
      check({par_en, isa_en, serr_req, par_rep}, 4'h0);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_values;
      t_readback;
      t_windows;
      t_errors;
      t_second_reset;
      tally_and_finish;
   end
endmodule // bridge_window_config_regs_bench

`default_nettype wire
